// ==== shared/ecr_pkg.sv ====
// Constants, register map and state type of the event channel router
package ecr_pkg;
    //------------------------------------------------------------------
    // Register byte offsets
    //------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_SWEVT   = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_INTFLAG = 8'h0C;
    localparam logic [7:0] ADDR_INTMASK = 8'h10;
    //------------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------------
    localparam int CTRL_EN      = 0;
    localparam int CTRL_PATH_LO = 1;
    localparam int CTRL_ONREQ   = 3;
    localparam int CTRL_USER_LO = 8;
    localparam int SWEVT_FIRE   = 0;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_INTBUSY = 1;
    localparam int INT_OVR      = 0;
    localparam int INT_DONE     = 1;
    localparam int INT_W        = 2;
    //------------------------------------------------------------------
    // Path encodings and reset values
    //------------------------------------------------------------------
    localparam logic [1:0] PATH_ASYNC  = 2'h0;
    localparam logic [1:0] PATH_SYNC   = 2'h1;
    localparam logic [1:0] PATH_RESYNC = 2'h2;
    localparam logic [1:0] INT_RESET   = 2'h0;
    //------------------------------------------------------------------
    // Timing in channel clock ticks
    //------------------------------------------------------------------
    localparam logic [1:0] POST_ACK_TICKS     = 2'h1;
    localparam logic [1:0] FREE_CLK_EXTRA     = 2'h1;
    localparam logic [1:0] RESYNC_DELAY_TICKS = 2'h2;
    localparam logic [1:0] SW_WAIT_TICKS      = 2'h3;
    //------------------------------------------------------------------
    // Channel state, Gray coded along idle-delay-busy-hold
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        ECR_IDLE  = 2'b00,
        ECR_DELAY = 2'b01,
        ECR_BUSY  = 2'b11,
        ECR_HOLD  = 2'b10
    } ecr_state_t;
endpackage

// ==== core/ecr_event_channel_router.sv ====
// One event routing channel with AHB-Lite register slave
//
// Overview of operation
// - Sync path with free-running channel clock can flag spurious overruns.
// - Busy flag clears on acknowledge; channel stays busy one more tick, two on sync path with free-running clock.
// - An event arriving in that extra tick sets the overrun flag.
// - Resync software event sets busy late; events in gap dropped silently.
// - After enable, channel busy one tick while busy flag stays low.
// - Hidden post-enable busy visible when channel clock is slower.
// - Pin user on sync/resync path never releases its acknowledge.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module ecr_event_channel_router #(
    parameter int NUM_USERS = 4,
    parameter int PIN_USER  = 0
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic                 channelGenericClock,
    input  wire logic                 genEvent,
    input  wire logic [NUM_USERS-1:0] userAck,
    output logic [NUM_USERS-1:0]      evtOut,
    output logic                      chanClkReq,
    output logic                      irq
);
    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    logic                 enable;
    logic [1:0]           path;
    logic                 onReq;
    logic [NUM_USERS-1:0] consumerSel;
    logic [ecr_pkg::INT_W-1:0] intFlag;
    logic [ecr_pkg::INT_W-1:0] intMask;
    logic                 swEvt;
    logic                 wrPend;
    logic [7:0]           wrAddr;
    logic [1:0]           clkSync;
    logic                 clkPrev;
    logic [1:0]           genSync;
    logic                 genPrev;
    logic [NUM_USERS-1:0] ackS1;
    logic [NUM_USERS-1:0] ackS2;
    logic [NUM_USERS-1:0] ackPrev;
    ecr_pkg::ecr_state_t  state;
    logic [1:0]           cnt;
    logic [NUM_USERS-1:0] pending;
    logic                 busyFlag;
    logic                 startBusy;
    logic                 tick;
    logic                 evtIn;
    logic                 routed;
    logic                 accept;
    logic                 ovrEvt;
    logic                 doneEvt;
    logic [NUM_USERS-1:0] pinMask;
    logic [NUM_USERS-1:0] ackEff;
    logic [NUM_USERS-1:0] next_pending;
    logic                 addrPhase;
    logic                 wrData;

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            ecr_pkg::ADDR_CTRL: begin
                r[ecr_pkg::CTRL_EN]                     = enable;
                r[ecr_pkg::CTRL_PATH_LO +: 2]           = path;
                r[ecr_pkg::CTRL_ONREQ]                  = onReq;
                r[ecr_pkg::CTRL_USER_LO +: NUM_USERS]   = consumerSel;
            end
            ecr_pkg::ADDR_STATUS: begin
                r[ecr_pkg::STAT_BUSY]    = busyFlag;
                r[ecr_pkg::STAT_INTBUSY] = (state != ecr_pkg::ECR_IDLE)
                                           | startBusy;
            end
            ecr_pkg::ADDR_INTFLAG: r[ecr_pkg::INT_W-1:0] = intFlag;
            ecr_pkg::ADDR_INTMASK: r[ecr_pkg::INT_W-1:0] = intMask;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    //------------------------------------------------------------------
    // Input synchronisers and edge detection
    //------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkSync <= 2'h0;
            clkPrev <= 1'b0;
            genSync <= 2'h0;
            genPrev <= 1'b0;
            ackS1   <= '0;
            ackS2   <= '0;
            ackPrev <= '0;
        end else begin
            clkSync <= {clkSync[0], channelGenericClock};
            clkPrev <= clkSync[1];
            genSync <= {genSync[0], genEvent};
            genPrev <= genSync[1];
            ackS1   <= userAck;
            ackS2   <= ackS1;
            ackPrev <= ackS2;
        end
    end

    // Channel clock sampled on clk: ticks slower than clk/4 are assumed
    assign tick  = clkSync[1] & ~clkPrev;
    assign evtIn = (genSync[1] & ~genPrev) | swEvt;
    assign routed = enable && (path != ecr_pkg::PATH_ASYNC);

    always_comb begin
        pinMask = '0;
        pinMask[PIN_USER] = 1'b1;
    end
    // Pin user acknowledge is lost on clocked paths
    assign ackEff = ackS2 & ~ackPrev & ~(routed ? pinMask : '0);
    assign next_pending = pending & ~ackEff;

    assign accept = routed && evtIn && !startBusy
                    && (state == ecr_pkg::ECR_IDLE);
    // Events in the resync gap are dropped without overrun
    assign ovrEvt = routed && evtIn
                    && (startBusy || (state == ecr_pkg::ECR_BUSY)
                        || (state == ecr_pkg::ECR_HOLD));
    assign doneEvt = (state == ecr_pkg::ECR_BUSY) && enable
                     && (next_pending == '0);

    //------------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    //------------------------------------------------------------------
    assign addrPhase = hsel && hready && htrans[1];
    assign wrData    = wrPend;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wrPend    <= 1'b0;
            wrAddr    <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend    <= addrPhase && hwrite;
            wrAddr    <= haddr;
            if (addrPhase && !hwrite) begin
                hrdata <= read_mux(haddr);
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable      <= 1'b0;
            path        <= ecr_pkg::PATH_ASYNC;
            onReq       <= 1'b0;
            consumerSel <= '0;
            intMask     <= ecr_pkg::INT_RESET;
            swEvt       <= 1'b0;
        end else begin
            swEvt <= wrData && (wrAddr == ecr_pkg::ADDR_SWEVT)
                     && hwdata[ecr_pkg::SWEVT_FIRE];
            if (wrData && (wrAddr == ecr_pkg::ADDR_CTRL)) begin
                enable      <= hwdata[ecr_pkg::CTRL_EN];
                path        <= hwdata[ecr_pkg::CTRL_PATH_LO +: 2];
                onReq       <= hwdata[ecr_pkg::CTRL_ONREQ];
                consumerSel <= hwdata[ecr_pkg::CTRL_USER_LO +: NUM_USERS];
            end
            if (wrData && (wrAddr == ecr_pkg::ADDR_INTMASK)) begin
                intMask <= hwdata[ecr_pkg::INT_W-1:0];
            end
        end
    end

    //------------------------------------------------------------------
    // Interrupt flags: set wins over write-one-to-clear
    //------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intFlag <= ecr_pkg::INT_RESET;
            irq     <= 1'b0;
        end else begin
            if (wrData && (wrAddr == ecr_pkg::ADDR_INTFLAG)) begin
                intFlag <= (intFlag & ~hwdata[ecr_pkg::INT_W-1:0])
                           | {doneEvt, ovrEvt};
            end else begin
                intFlag <= intFlag | {doneEvt, ovrEvt};
            end
            irq <= |(intFlag & intMask);
        end
    end

    //------------------------------------------------------------------
    // Post-enable hidden busy tick
    //------------------------------------------------------------------
    // Lasts one channel tick, so it spans many clk cycles when the
    // channel clock is slow and software can trip over it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startBusy <= 1'b0;
        end else begin
            // Set by the enabling write itself, so no trigger slips in
            if (wrData && (wrAddr == ecr_pkg::ADDR_CTRL)
                && hwdata[ecr_pkg::CTRL_EN] && !enable) begin
                startBusy <= 1'b1;
            end else if (tick || !enable) begin
                startBusy <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // Channel state machine
    //------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ecr_pkg::ECR_IDLE;
            cnt      <= 2'h0;
            pending  <= '0;
            busyFlag <= 1'b0;
        end else if (!enable) begin
            state    <= ecr_pkg::ECR_IDLE;
            cnt      <= 2'h0;
            pending  <= '0;
            busyFlag <= 1'b0;
        end else begin
            case (state)
                ecr_pkg::ECR_IDLE: begin
                    if (accept && path == ecr_pkg::PATH_RESYNC) begin
                        state <= ecr_pkg::ECR_DELAY;
                        cnt   <= 2'h0;
                    end else if (accept) begin
                        state    <= ecr_pkg::ECR_BUSY;
                        pending  <= consumerSel;
                        busyFlag <= 1'b1;
                    end
                end
                ecr_pkg::ECR_DELAY: begin
                    if (tick && cnt == ecr_pkg::RESYNC_DELAY_TICKS - 2'h1)
                    begin
                        state    <= ecr_pkg::ECR_BUSY;
                        pending  <= consumerSel;
                        busyFlag <= 1'b1;
                    end else if (tick) begin
                        cnt <= cnt + 2'h1;
                    end
                end
                ecr_pkg::ECR_BUSY: begin
                    pending <= next_pending;
                    if (next_pending == '0) begin
                        state    <= ecr_pkg::ECR_HOLD;
                        busyFlag <= 1'b0;
                        // Free-running clock stretches the window
                        if (path == ecr_pkg::PATH_SYNC && !onReq) begin
                            cnt <= ecr_pkg::POST_ACK_TICKS
                                   + ecr_pkg::FREE_CLK_EXTRA - 2'h1;
                        end else begin
                            cnt <= ecr_pkg::POST_ACK_TICKS - 2'h1;
                        end
                    end
                end
                ecr_pkg::ECR_HOLD: begin
                    if (tick && cnt == 2'h0) begin
                        state <= ecr_pkg::ECR_IDLE;
                    end else if (tick) begin
                        cnt <= cnt - 2'h1;
                    end
                end
                default: state <= ecr_pkg::ECR_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Event delivery and channel clock request
    //------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evtOut     <= '0;
            chanClkReq <= 1'b0;
        end else begin
            if (enable && path == ecr_pkg::PATH_ASYNC && evtIn) begin
                evtOut <= consumerSel;
            end else if (accept && path != ecr_pkg::PATH_RESYNC) begin
                evtOut <= consumerSel;
            end else if (state == ecr_pkg::ECR_DELAY && enable && tick
                         && cnt == ecr_pkg::RESYNC_DELAY_TICKS - 2'h1) begin
                evtOut <= consumerSel;
            end else begin
                evtOut <= '0;
            end
            if (onReq) begin
                chanClkReq <= (state != ecr_pkg::ECR_IDLE) || startBusy
                              || evtIn;
            end else begin
                chanClkReq <= enable;
            end
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ovr_sets_flag: assert property (ovrEvt |=> intFlag[0])
        else $error("overrun did not set its flag");
    a_hold_overrun: assert property (
        (state == ecr_pkg::ECR_HOLD && routed && evtIn) |-> ovrEvt)
        else $error("event in post-ack tick not flagged");
    a_busy_fall_hold: assert property (
        ($fell(busyFlag) && enable) |-> state == ecr_pkg::ECR_HOLD)
        else $error("busy cleared without hold tick");
    a_resync_drop: assert property (
        (state == ecr_pkg::ECR_DELAY && evtIn) |-> !ovrEvt && !busyFlag)
        else $error("resync gap event mishandled");
    a_enable_hidden: assert property (
        startBusy |-> !busyFlag && (!(routed && evtIn) || ovrEvt))
        else $error("post-enable busy tick wrong");
    a_pin_ack_lost: assert property (
        routed |-> (ackEff & pinMask) == '0)
        else $error("pin user acknowledge released");
    a_busy_on_entry: assert property (
        (accept && path == ecr_pkg::PATH_SYNC) |=> busyFlag ##0 evtOut != '0
            || consumerSel == '0)
        else $error("sync entry did not raise busy");
    a_free_clk_hold: assert property (
        (state == ecr_pkg::ECR_BUSY && next_pending == '0 && enable
         && path == ecr_pkg::PATH_SYNC && !onReq)
        |=> cnt == ecr_pkg::FREE_CLK_EXTRA)
        else $error("free-running hold window wrong");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready OKAY");

    c_hold_overrun: cover property (state == ecr_pkg::ECR_HOLD && ovrEvt);
    c_resync_done:  cover property (state == ecr_pkg::ECR_DELAY
                                    ##[1:200] state == ecr_pkg::ECR_BUSY);
    c_async_event:  cover property (!routed && enable && evtOut != '0);
endmodule // ecr_event_channel_router

// ==== bench/ecr_event_partner.sv ====
// Event user model that acknowledges each delivered event after a delay
`timescale 1ns/1ps
module ecr_event_partner #(
    parameter int NUM_USERS = 4
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [NUM_USERS-1:0] evtOut,
    input  wire logic                 slowAck,
    output logic      [NUM_USERS-1:0] userAck
);
    // ------------------------------------------------------------
    // Per-user acknowledge
    // ------------------------------------------------------------
    logic [4:0] waitCnt [NUM_USERS];

    // Ack is held two cycles so the two-stage synchroniser sees it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            userAck <= '0;
            for (int i = 0; i < NUM_USERS; i++) waitCnt[i] <= 5'h00;
        end else begin
            for (int i = 0; i < NUM_USERS; i++) begin
                if (evtOut[i]) begin
                    waitCnt[i] <= slowAck ? 5'h11 : 5'h03;
                end else if (waitCnt[i] != 5'h00) begin
                    waitCnt[i] <= waitCnt[i] - 5'h01;
                end
                userAck[i] <= (waitCnt[i] == 5'h02) ||
                              (waitCnt[i] == 5'h01);
            end
        end
    end
endmodule // ecr_event_partner

// ==== bench/test_ecr_event_channel_router.sv ====
// Self-checking bench for the event channel router
`timescale 1ns/1ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin \
    mismatches++; $display("unexpected at %0t: got %h want %h", \
    $time, act, exp); end end
module test_ecr_event_channel_router;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic        hsel     = 1'b0;
    logic        hwrite   = 1'b0;
    logic        genEvent = 1'b0;
    logic        slowAck  = 1'b1;
    logic [1:0]  htrans   = 2'h0;
    logic [2:0]  hsize    = 3'h2;
    logic [7:0]  haddr    = 8'h00;
    logic [31:0] hwdata   = 32'h0;
    logic [3:0]  ckCnt    = 4'h0;
    logic [7:0]  evtCnt [4] = '{default: 8'h00};
    logic        hready, hreadyout, hresp, irq, chanClkReq;
    logic [31:0] hrdata, rd;
    logic [3:0]  evtOut, userAck;
    int          mismatches = 0;
    int          checked    = 0;

    assign hready = hreadyout;
    always #12.5 clk = ~clk;
    // Channel clock: one tick every 16 clk, rising when ckCnt steps from 7 to 8
    always @(posedge clk) ckCnt <= ckCnt + 4'h1;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) evtCnt[i] <= evtCnt[i] + evtOut[i];
    end

    ecr_event_channel_router u_dut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .channelGenericClock(ckCnt[3]),
        .genEvent(genEvent), .userAck(userAck), .evtOut(evtOut),
        .chanClkReq(chanClkReq), .irq(irq)
    );
    ecr_event_partner u_users (
        .clk(clk), .rst_n(rst_n), .evtOut(evtOut), .slowAck(slowAck),
        .userAck(userAck)
    );

    // ------------------------------------------------------------
    // Bus and event tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Registered slave: ready and data stand the whole cycle
    task automatic waitRdy(output logic [31:0] d);
        int   n;
        logic r;
        n = 0;
        do begin
            @(negedge clk);
            d = hrdata;
            r = hready;
            @(posedge clk);
            n++;
            `CHK(hresp, 1'b0)
        end while (r !== 1'b1 && n < 20);
        if (r !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: bus hang", $time);
            final_report();
        end
    endtask

    task automatic busXfer(input logic w, input logic [7:0] a,
                           input logic [31:0] v, output logic [31:0] d);
        logic [31:0] x;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        waitRdy(x);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        if (w) hwdata <= v;
        waitRdy(d);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        busXfer(1'b1, a, v, d);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        busXfer(1'b0, a, 32'h0, d);
        `CHK(d, e)
    endtask

    task automatic sw;
        wr(ecr_pkg::ADDR_SWEVT, 32'h1);
    endtask

    task automatic gen;
        genEvent <= 1'b1;
        repeat (3) @(posedge clk);
        genEvent <= 1'b0;
        @(posedge clk);
    endtask

    task automatic ticks(input int n);
        repeat (16 * n) @(posedge clk);
    endtask

    // Returns on the edge where the channel clock rises
    task automatic align;
        do @(posedge clk); while (ckCnt != 4'h7);
    endtask

    task automatic pollIdle;
        int n;
        n = 0;
        do begin
            busXfer(1'b0, ecr_pkg::ADDR_STATUS, 32'h0, rd);
            n++;
        end while (rd[0] !== 1'b0 && n < 40);
        if (rd[0] !== 1'b0) begin
            mismatches++;
            $display("unexpected at %0t: busy stuck", $time);
            final_report();
        end
    endtask

    function automatic logic [31:0] ctrl(input logic [1:0] p,
                                         input logic o, input logic [3:0] u);
        ctrl = {20'h0, u, 4'h0, o, p, 1'b1};
    endfunction

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("unexpected at %0t: run too long", $time);
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdChk(ecr_pkg::ADDR_CTRL, 32'h0);
        rdChk(ecr_pkg::ADDR_STATUS, 32'h0);
        rdChk(ecr_pkg::ADDR_INTFLAG, 32'h0);
        rdChk(ecr_pkg::ADDR_INTMASK, 32'h0);
        wr(8'h14, 32'hFFFFFFFF);
        rdChk(8'h14, 32'h0);
        $display("test reset done");
        // Event inside the hidden start-busy tick is refused
        align();
        repeat (4) @(posedge clk);
        wr(ecr_pkg::ADDR_CTRL, ctrl(ecr_pkg::PATH_SYNC, 1'b1, 4'h2));
        rdChk(ecr_pkg::ADDR_STATUS, 32'h2);
        `CHK(chanClkReq, 1'b1)
        gen();
        rdChk(ecr_pkg::ADDR_INTFLAG, 32'h1);
        `CHK(evtCnt[1], 8'h00)
        wr(ecr_pkg::ADDR_INTFLAG, 32'h3);
        rdChk(ecr_pkg::ADDR_INTFLAG, 32'h0);
        $display("test start busy done");
        // Sync path, slow ack, event right after the busy flag clears
        align();
        gen();
        repeat (8) @(posedge clk);
        rdChk(ecr_pkg::ADDR_STATUS, 32'h3);
        `CHK(evtCnt[1], 8'h01)
        `CHK(evtCnt[2], 8'h00)
        pollIdle();
        gen();
        rdChk(ecr_pkg::ADDR_INTFLAG, 32'h3);
        `CHK(evtCnt[1], 8'h01)
        wr(ecr_pkg::ADDR_INTFLAG, 32'h3);
        $display("test post ack window done");
        // Waiting one tick after busy clears avoids the overrun
        slowAck <= 1'b0;
        ticks(2);
        align();
        gen();
        pollIdle();
        ticks(1);
        sw();
        repeat (12) @(posedge clk);
        rdChk(ecr_pkg::ADDR_INTFLAG, 32'h2);
        `CHK(evtCnt[1], 8'h03)
        $display("test spaced events done");
        // Resync: second software event in the delay is lost silently
        wr(ecr_pkg::ADDR_CTRL, 32'h0);
        wr(ecr_pkg::ADDR_CTRL, ctrl(ecr_pkg::PATH_RESYNC, 1'b1, 4'h2));
        ticks(2);
        wr(ecr_pkg::ADDR_INTFLAG, 32'h3);
        sw();
        sw();
        busXfer(1'b0, ecr_pkg::ADDR_STATUS, 32'h0, rd);
        `CHK(rd[0], 1'b0)
        ticks(4);
        rdChk(ecr_pkg::ADDR_INTFLAG, 32'h2);
        `CHK(evtCnt[1], 8'h04)
        $display("test resync done");
        // Pin user on sync path: ack ignored, next event overruns
        wr(ecr_pkg::ADDR_CTRL, 32'h0);
        wr(ecr_pkg::ADDR_CTRL, ctrl(ecr_pkg::PATH_SYNC, 1'b1, 4'h1));
        ticks(2);
        wr(ecr_pkg::ADDR_INTFLAG, 32'h3);
        sw();
        ticks(2);
        rdChk(ecr_pkg::ADDR_STATUS, 32'h3);
        `CHK(evtCnt[0], 8'h01)
        wr(ecr_pkg::ADDR_INTMASK, 32'h1);
        `CHK(irq, 1'b0)
        sw();
        repeat (8) @(posedge clk);
        rdChk(ecr_pkg::ADDR_INTFLAG, 32'h1);
        `CHK(irq, 1'b1)
        wr(ecr_pkg::ADDR_INTMASK, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(ecr_pkg::ADDR_INTMASK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(ecr_pkg::ADDR_INTFLAG, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        rdChk(ecr_pkg::ADDR_INTMASK, 32'h1);
        $display("test pin user done");
        // Pin user over the asynchronous path keeps working
        wr(ecr_pkg::ADDR_CTRL, 32'h0);
        wr(ecr_pkg::ADDR_CTRL, ctrl(ecr_pkg::PATH_ASYNC, 1'b0, 4'h1));
        repeat (2) @(posedge clk);
        `CHK(chanClkReq, 1'b1)
        ticks(1);
        sw();
        repeat (6) @(posedge clk);
        sw();
        repeat (6) @(posedge clk);
        `CHK(evtCnt[0], 8'h03)
        rdChk(ecr_pkg::ADDR_STATUS, 32'h0);
        wr(ecr_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(chanClkReq, 1'b0)
        $display("test async pin user done");
        // Free-running clock on sync path keeps the post-ack window longer
        wr(ecr_pkg::ADDR_CTRL, ctrl(ecr_pkg::PATH_SYNC, 1'b0, 4'h2));
        ticks(2);
        wr(ecr_pkg::ADDR_INTFLAG, 32'h3);
        align();
        gen();
        pollIdle();
        ticks(1);
        gen();
        rdChk(ecr_pkg::ADDR_INTFLAG, 32'h3);
        `CHK(evtCnt[1], 8'h05)
        $display("test free clock done");
        final_report();
    end
endmodule // test_ecr_event_channel_router
